// [bench/message_queue_list_pointers_tb.sv]
// Purpose: self-checking bench for the list pointer block
// Assumes: registered AXI4-Lite answers; queue writes from the host model
// Notes:   expected read words are queued and compared by a monitor
`timescale 1ns/1ps
`define check(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module message_queue_list_pointers_tb;
   import message_queue_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic ref_clk_i, rst_i, pci_in, pci_out, load, slow, busy;
   logic [11:0] queue_base_address_i, s_axi_awaddr_i, s_axi_araddr_i, bv;
   logic [2:0] queue_size_i;
   logic [3:0] n_in, n_out, s_axi_wstrb_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
   logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
   logic [17:0] ipb, ipt, ofb, oft;
   logic [17:0] e[4];
   logic [11:0] pa[4];
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   int n_fail, comparisons;

   message_queue_list_pointers i_message_queue_list_pointers (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .queue_base_address_i(queue_base_address_i),
      .queue_size_i(queue_size_i), .pci_inbound_write_i(pci_in), .pci_outbound_write_i(pci_out),
      .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
      .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
      .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
      .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
      .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
      .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .inbound_post_bottom_o(ipb),
      .inbound_post_top_o(ipt), .outbound_free_bottom_o(ofb), .outbound_free_top_o(oft));
   pci_queue_model i_pci_queue_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .load_i(load), .in_count_i(n_in),
      .out_count_i(n_out), .slow_i(slow), .pci_inbound_write_o(pci_in), .pci_outbound_write_o(pci_out),
      .busy_o(busy));

   // clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = !ref_clk_i;
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [17:0] msk(input int s);
      case (s)
         2: msk = 18'h03FFC;
         3: msk = 18'h0FFFC;
         4: msk = 18'h3FFFC;
         default: msk = 18'h00FFC;
      endcase
   endfunction : msk

   function automatic logic [17:0] adv(input logic [17:0] p, input int s);
      adv = (p & ~msk(s)) | ((p + 18'h00004) & msk(s));
   endfunction : adv

   task automatic results();
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   // one write, address and data offered together
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      int i;
      exp_b.push_back(r);
      @(posedge ref_clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge ref_clk_i);
         if (s_axi_awvalid_i && s_axi_awready_o === 1'b1)
            s_axi_awvalid_i <= 1'b0;
         if (s_axi_wvalid_i && s_axi_wready_o === 1'b1)
            s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o === 1'b1)
            break;
      end
      s_axi_bready_i <= 1'b0;
      if (i == 50)
      begin
         n_fail++;
         results();
      end
   endtask : wr

   // one read, the expected word is noted for the monitor
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int i;
      exp_r.push_back({r, d});
      @(posedge ref_clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge ref_clk_i);
         if (s_axi_arvalid_i && s_axi_arready_o === 1'b1)
            s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o === 1'b1)
            break;
      end
      s_axi_rready_i <= 1'b0;
      if (i == 50)
      begin
         n_fail++;
         results();
      end
   endtask : rd

   // all words and pointer outputs against the expected state
   task automatic check_regs();
      int k;
      for (k = 0; k < 4; k++)
         rd(pa[k], {bv, 2'b00, e[k][17:2], 2'b00}, RESP_OKAY);
      rd(INBOUND_POST_BOTTOM_INCREMENT, 32'h00000000, RESP_OKAY);
      rd(OUTBOUND_FREE_BOTTOM_INCREMENT, 32'h00000000, RESP_OKAY);
      `check("inbound bottom", e[0], ipb)
      `check("inbound top", e[1], ipt)
      `check("outbound bottom", e[2], ofb)
      `check("outbound top", e[3], oft)
   endtask : check_regs

   // monitor: each answer takes the oldest note
   always @(posedge ref_clk_i)
   begin
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i && exp_r.size() > 0)
      begin
         `check("rdata", exp_r[0][31:0], s_axi_rdata_o)
         `check("rresp", exp_r[0][33:32], s_axi_rresp_o)
         void'(exp_r.pop_front());
      end
      if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i && exp_b.size() > 0)
      begin
         `check("bresp", exp_b[0], s_axi_bresp_o)
         void'(exp_b.pop_front());
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      int sz, k, i;
      logic [17:0] v[2];
      logic [31:0] d;
      {rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 6'h20;
      {queue_base_address_i, bv, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
      {queue_size_i, n_in, n_out, s_axi_wstrb_i, load, slow} = '0;
      pa = '{INBOUND_POST_BOTTOM_POINTER, INBOUND_POST_TOP_POINTER, OUTBOUND_FREE_BOTTOM_POINTER,
             OUTBOUND_FREE_TOP_POINTER};
      e = '{default: 18'h00000};
      void'($urandom(66074));
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      check_regs();
      for (sz = 0; sz < 6; sz++)
      begin
         bv = 12'($urandom());
         queue_base_address_i <= bv;
         queue_size_i <= 3'(sz);
         // bottom and top of each queue start equal, window bits full so the next step wraps
         v[0] = 18'($urandom()) | msk(sz);
         v[1] = 18'($urandom()) | msk(sz);
         for (k = 0; k < 4; k++)
         begin
            d = $urandom();
            d[17:0] = v[k / 2];
            wr(pa[k], d, 4'hF, RESP_OKAY);
            e[k] = v[k / 2] & 18'h3FFFC;
         end
         wr(INBOUND_POST_BOTTOM_INCREMENT, 32'h00000000, 4'hF, RESP_OKAY);
         wr(OUTBOUND_FREE_BOTTOM_INCREMENT, 32'h00000001, 4'hE, RESP_OKAY);
         wr(INBOUND_POST_BOTTOM_INCREMENT, $urandom() | 32'h1, 4'hF, RESP_OKAY);
         wr(OUTBOUND_FREE_BOTTOM_INCREMENT, 32'h00000001, 4'h1, RESP_OKAY);
         e[0] = adv(e[0], sz);
         e[2] = adv(e[2], sz);
         // host writes to both queues, fast or spaced
         @(posedge ref_clk_i);
         n_in <= 4'($urandom_range(1, 9));
         n_out <= 4'($urandom_range(1, 9));
         slow <= 1'($urandom());
         load <= 1'b1;
         @(posedge ref_clk_i);
         load <= 1'b0;
         for (i = 0; i < n_in; i++)
            e[1] = adv(e[1], sz);
         for (i = 0; i < n_out; i++)
            e[3] = adv(e[3], sz);
         for (i = 0; i < 40; i++)
         begin
            @(negedge ref_clk_i);
            if (busy === 1'b0)
               break;
         end
         if (i == 40)
         begin
            n_fail++;
            results();
         end
         check_regs();
      end
      wr(12'h534, $urandom(), 4'hF, RESP_SLVERR);
      rd(12'h000, 32'h00000000, RESP_SLVERR);
      wr(pa[1], 32'hFFFFFFFF, 4'h1, RESP_OKAY);
      e[1] = {e[1][17:8], 8'hFC};
      check_regs();
      // reset in mid-run clears every pointer
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      e = '{default: 18'h00000};
      check_regs();
      results();
   end
endmodule : message_queue_list_pointers_tb

// [bench/pci_queue_model.sv]
// Purpose: host side that posts writes to the inbound and outbound queues
// Assumes: counts are loaded by a one-cycle load pulse
// Notes:   slow mode spaces writes one idle cycle apart
`timescale 1ns/1ps
module pci_queue_model
(
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // commands from the bench
   input  wire logic       load_i,
   input  wire logic [3:0] in_count_i,
   input  wire logic [3:0] out_count_i,
   input  wire logic       slow_i,
   // queue write pulses
   output logic            pci_inbound_write_o,
   output logic            pci_outbound_write_o,
   output logic            busy_o
);
   logic [3:0] in_left;
   logic [3:0] out_left;
   logic       phase;

   // a write goes out on every cycle, or every other one when slow
   assign pci_inbound_write_o  = (in_left != 4'h0) && (phase || !slow_i);
   assign pci_outbound_write_o = (out_left != 4'h0) && (phase || !slow_i);
   assign busy_o               = (in_left != 4'h0) || (out_left != 4'h0);

   // pending write counters
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         in_left  <= 4'h0;
         out_left <= 4'h0;
         phase    <= 1'b0;
      end
      else if (load_i)
      begin
         in_left  <= in_count_i;
         out_left <= out_count_i;
      end
      else
      begin
         phase <= !phase;
         if (pci_inbound_write_o)
            in_left <= in_left - 4'h1;
         if (pci_outbound_write_o)
            out_left <= out_left - 4'h1;
      end
   end
endmodule : pci_queue_model

// [logic/base_holder.sv]
// Purpose: registered copy of the processor-bus queue base address
// Assumes: base input is synchronous to ref_clk_i
// Notes:   read only from the register bus
`timescale 1ns/1ps
module base_holder
   import message_queue_pkg::*;
(
   // clock and reset
   input  logic              ref_clk_i,
   input  logic              rst_i,
   // base in and out
   input  logic [BASE_W-1:0] queue_base_address_i,
   output logic [BASE_W-1:0] base_o
);

   // follow the base once reset is released
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         base_o <= BASE_RESET;
      else
         base_o <= queue_base_address_i;
   end

endmodule : base_holder

// [logic/list_pointer.sv]
// Purpose: one list pointer, loaded by software, advanced by hardware
// Assumes: load and advance are single-cycle pulses
// Notes:   a load in the same cycle as an advance wins
`timescale 1ns/1ps
module list_pointer
   import message_queue_pkg::*;
(
   // clock and reset
   input  logic              ref_clk_i,
   input  logic              rst_i,
   // control
   input  logic              load_i,
   input  logic [PTR_W-1:0]  load_value_i,
   input  logic              advance_i,
   input  logic [SIZE_W-1:0] size_i,
   // state
   output logic [PTR_W-1:0]  ptr_o
);

   logic [PTR_W-1:0] mask;
   logic [PTR_W-1:0] stepped;

   // step by four inside the window of the configured size
   always_comb
   begin
      mask    = size_mask(size_i);
      stepped = (ptr_o & ~mask) | ((ptr_o + PTR_STEP) & mask);
   end

   // pointer register
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ptr_o <= PTR_RESET;
      else if (load_i)
         ptr_o <= {load_value_i[PTR_W-1:2], 2'b00};
      else if (advance_i)
         ptr_o <= stepped;
   end

endmodule : list_pointer

// [logic/message_queue_list_pointers.sv]
// Purpose: inbound post and outbound free list pointers behind AXI4-Lite
// Assumes: PCI queue write strobes are one-cycle pulses on ref_clk_i
// Notes:   one write and one read in flight at a time
`timescale 1ns/1ps
module message_queue_list_pointers
   import message_queue_pkg::*;
(
   // clock and reset
   input  logic              ref_clk_i,
   input  logic              rst_i,
   // queue configuration and events
   input  logic [BASE_W-1:0] queue_base_address_i,
   input  logic [SIZE_W-1:0] queue_size_i,
   input  logic              pci_inbound_write_i,
   input  logic              pci_outbound_write_i,
   // axi write address and data
   input  logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  logic              s_axi_awvalid_i,
   output logic              s_axi_awready_o,
   input  logic [31:0]       s_axi_wdata_i,
   input  logic [3:0]        s_axi_wstrb_i,
   input  logic              s_axi_wvalid_i,
   output logic              s_axi_wready_o,
   // axi write response
   output logic [1:0]        s_axi_bresp_o,
   output logic              s_axi_bvalid_o,
   input  logic              s_axi_bready_i,
   // axi read
   input  logic [ADDR_W-1:0] s_axi_araddr_i,
   input  logic              s_axi_arvalid_i,
   output logic              s_axi_arready_o,
   output logic [31:0]       s_axi_rdata_o,
   output logic [1:0]        s_axi_rresp_o,
   output logic              s_axi_rvalid_o,
   input  logic              s_axi_rready_i,
   // pointer state for the queue engines
   output logic [PTR_W-1:0]  inbound_post_bottom_o,
   output logic [PTR_W-1:0]  inbound_post_top_o,
   output logic [PTR_W-1:0]  outbound_free_bottom_o,
   output logic [PTR_W-1:0]  outbound_free_top_o
);

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------

   // merge written byte lanes into a pointer, low bits forced to zero
   function automatic logic [17:0] merge_ptr(input logic [17:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
      logic [17:0] v;
      v = old;
      if (strb[0])
         v[7:0] = data[7:0];
      if (strb[1])
         v[15:8] = data[15:8];
      if (strb[2])
         v[17:16] = data[17:16];
      v[1:0] = 2'b00;
      merge_ptr = v;
   endfunction : merge_ptr

   // full pointer word as seen on the bus
   function automatic logic [31:0] ptr_word(input logic [11:0] base,
                                            input logic [17:0] ptr);
      ptr_word = {base, 2'b00, ptr[17:2], 2'b00};
   endfunction : ptr_word

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              wr_fire;
   logic              wr_hit;
   logic [BASE_W-1:0] base;
   logic              ipb_load;
   logic              ipt_load;
   logic              ofb_load;
   logic              oft_load;
   logic              ipb_adv;
   logic              ofb_adv;
   logic [PTR_W-1:0]  ipb_ptr;
   logic [PTR_W-1:0]  ipt_ptr;
   logic [PTR_W-1:0]  ofb_ptr;
   logic [PTR_W-1:0]  oft_ptr;
   logic [PTR_W-1:0]  mask;
   logic [31:0]       next_rdata;
   logic              next_rhit;

   // ---------------------------------------------------------------
   // write channel
   // ---------------------------------------------------------------

   // address and data held until the response is taken
   assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

   // write address capture
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_awready_o <= 1'b1;
         aw_addr         <= '0;
      end
      else if (s_axi_awvalid_i && s_axi_awready_o)
      begin
         s_axi_awready_o <= 1'b0;
         aw_addr         <= s_axi_awaddr_i;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
         s_axi_awready_o <= 1'b1;
   end

   // write data capture
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_wready_o <= 1'b1;
         w_data         <= '0;
         w_strb         <= '0;
      end
      else if (s_axi_wvalid_i && s_axi_wready_o)
      begin
         s_axi_wready_o <= 1'b0;
         w_data         <= s_axi_wdata_i;
         w_strb         <= s_axi_wstrb_i;
      end
      else if (s_axi_bvalid_o && s_axi_bready_i)
         s_axi_wready_o <= 1'b1;
   end

   // address decode for the write
   always_comb
   begin
      case (aw_addr)
         INBOUND_POST_BOTTOM_POINTER,
         INBOUND_POST_BOTTOM_INCREMENT,
         INBOUND_POST_TOP_POINTER,
         OUTBOUND_FREE_BOTTOM_POINTER,
         OUTBOUND_FREE_BOTTOM_INCREMENT,
         OUTBOUND_FREE_TOP_POINTER: wr_hit = 1'b1;
         default:                   wr_hit = 1'b0;
      endcase
   end

   // write response
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_i)
         s_axi_bvalid_o <= 1'b0;
   end

   // ---------------------------------------------------------------
   // pointer control
   // ---------------------------------------------------------------

   // loads from software and advance-bit writes
   always_comb
   begin
      ipb_load = wr_fire && (aw_addr == INBOUND_POST_BOTTOM_POINTER);
      ipt_load = wr_fire && (aw_addr == INBOUND_POST_TOP_POINTER);
      ofb_load = wr_fire && (aw_addr == OUTBOUND_FREE_BOTTOM_POINTER);
      oft_load = wr_fire && (aw_addr == OUTBOUND_FREE_TOP_POINTER);
      ipb_adv  = wr_fire && (aw_addr == INBOUND_POST_BOTTOM_INCREMENT)
                 && w_strb[0] && w_data[ADVANCE_BIT];
      ofb_adv  = wr_fire && (aw_addr == OUTBOUND_FREE_BOTTOM_INCREMENT)
                 && w_strb[0] && w_data[ADVANCE_BIT];
      mask     = size_mask(queue_size_i);
   end

   // queue base copy
   base_holder u_base (
      .ref_clk_i            (ref_clk_i),
      .rst_i                (rst_i),
      .queue_base_address_i (queue_base_address_i),
      .base_o               (base)
   );

   // inbound post bottom, moved only by its advance bit
   list_pointer u_ipb (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .load_i       (ipb_load),
      .load_value_i (merge_ptr(ipb_ptr, w_data, w_strb)),
      .advance_i    (ipb_adv),
      .size_i       (queue_size_i),
      .ptr_o        (ipb_ptr)
   );

   // inbound post top, moved by each pci inbound queue write
   list_pointer u_ipt (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .load_i       (ipt_load),
      .load_value_i (merge_ptr(ipt_ptr, w_data, w_strb)),
      .advance_i    (pci_inbound_write_i),
      .size_i       (queue_size_i),
      .ptr_o        (ipt_ptr)
   );

   // outbound free bottom, moved only by its advance bit
   list_pointer u_ofb (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .load_i       (ofb_load),
      .load_value_i (merge_ptr(ofb_ptr, w_data, w_strb)),
      .advance_i    (ofb_adv),
      .size_i       (queue_size_i),
      .ptr_o        (ofb_ptr)
   );

   // outbound free top, moved by each pci outbound queue write
   list_pointer u_oft (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .load_i       (oft_load),
      .load_value_i (merge_ptr(oft_ptr, w_data, w_strb)),
      .advance_i    (pci_outbound_write_i),
      .size_i       (queue_size_i),
      .ptr_o        (oft_ptr)
   );

   // pointer outputs straight from the pointer flops
   assign inbound_post_bottom_o  = ipb_ptr;
   assign inbound_post_top_o     = ipt_ptr;
   assign outbound_free_bottom_o = ofb_ptr;
   assign outbound_free_top_o    = oft_ptr;

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------

   // read data mux
   always_comb
   begin
      next_rhit  = 1'b1;
      case (s_axi_araddr_i)
         INBOUND_POST_BOTTOM_POINTER:    next_rdata = ptr_word(base, ipb_ptr);
         INBOUND_POST_TOP_POINTER:       next_rdata = ptr_word(base, ipt_ptr);
         OUTBOUND_FREE_BOTTOM_POINTER:   next_rdata = ptr_word(base, ofb_ptr);
         OUTBOUND_FREE_TOP_POINTER:      next_rdata = ptr_word(base, oft_ptr);
         INBOUND_POST_BOTTOM_INCREMENT,
         OUTBOUND_FREE_BOTTOM_INCREMENT: next_rdata = 32'h00000000;
         default:
         begin
            next_rdata = 32'h00000000;
            next_rhit  = 1'b0;
         end
      endcase
   end

   // read handshake and data register
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= next_rdata;
         s_axi_rresp_o   <= next_rhit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // base field follows the base copy
   base_field_a: assert property (
      (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == OUTBOUND_FREE_TOP_POINTER)
      |=> s_axi_rdata_o[31:BASE_LSB] == $past(base))
      else $error("base field wrong in pointer read");

   // bottom pointer stands still without its advance
   bottom_hold_a: assert property (
      (!ipb_adv && !ipb_load) |=> $stable(ipb_ptr))
      else $error("inbound post bottom moved on its own");

   // inbound bottom advance by four
   ipb_step_a: assert property (
      (ipb_adv && !ipb_load)
      |=> (ipb_ptr & $past(mask)) == (($past(ipb_ptr) + PTR_STEP) & $past(mask)))
      else $error("inbound post bottom did not step by four");

   // inbound top advance on pci write
   ipt_step_a: assert property (
      (pci_inbound_write_i && !ipt_load)
      |=> (ipt_ptr & $past(mask)) == (($past(ipt_ptr) + PTR_STEP) & $past(mask)))
      else $error("inbound post top did not step by four");

   // outbound bottom advance by four
   ofb_step_a: assert property (
      (ofb_adv && !ofb_load)
      |=> (ofb_ptr & $past(mask)) == (($past(ofb_ptr) + PTR_STEP) & $past(mask)))
      else $error("outbound free bottom did not step by four");

   // outbound top advance on pci write
   oft_step_a: assert property (
      (pci_outbound_write_i && !oft_load)
      |=> (oft_ptr & $past(mask)) == (($past(oft_ptr) + PTR_STEP) & $past(mask)))
      else $error("outbound free top did not step by four");

   // inbound top advance leaves bits above the size window alone
   wrap_window_a: assert property (
      (pci_inbound_write_i && !ipt_load)
      |=> (ipt_ptr & ~$past(mask)) == ($past(ipt_ptr) & ~$past(mask)))
      else $error("pointer advance escaped the size window");

   // pointer low bits always zero
   ptr_align_a: assert property (
      (ipb_ptr[1:0] == 2'b00) && (ipt_ptr[1:0] == 2'b00)
      && (ofb_ptr[1:0] == 2'b00) && (oft_ptr[1:0] == 2'b00))
      else $error("pointer lost four-byte alignment");

   // advance register reads as zero
   inc_read_a: assert property (
      (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == INBOUND_POST_BOTTOM_INCREMENT)
      |=> s_axi_rvalid_o && s_axi_rdata_o == 32'h00000000)
      else $error("advance register read not zero");

   // pointer placed at its offset
   ipb_map_a: assert property (
      (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == INBOUND_POST_BOTTOM_POINTER)
      |=> s_axi_rdata_o[17:0] == $past(ipb_ptr))
      else $error("inbound post bottom not at its offset");

   // response follows the held write by one cycle
   write_resp_a: assert property (
      (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o)
      |=> ##1 s_axi_bvalid_o)
      else $error("write response late");

endmodule : message_queue_list_pointers

// [logic/message_queue_pkg.sv]
// Purpose: constants shared by the message queue list pointer block
// Assumes: 32-bit register words, byte offsets printed as byte addresses
// Notes:   the size mask decode lives here so every pointer uses one copy
package message_queue_pkg;

   // ---------------------------------------------------------------
   // field widths and positions
   // ---------------------------------------------------------------
   localparam int          PTR_W      = 18;
   localparam int          BASE_W     = 12;
   localparam int          BASE_LSB   = 20;
   localparam int          ADDR_W     = 12;
   localparam int          SIZE_W     = 3;
   localparam logic [17:0] PTR_STEP   = 18'h00004;
   localparam logic [17:0] PTR_RESET  = 18'h00000;
   localparam logic [11:0] BASE_RESET = 12'h000;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] INBOUND_POST_BOTTOM_POINTER    = 12'h51C;
   localparam logic [11:0] INBOUND_POST_BOTTOM_INCREMENT  = 12'h520;
   localparam logic [11:0] INBOUND_POST_TOP_POINTER       = 12'h524;
   localparam logic [11:0] OUTBOUND_FREE_BOTTOM_POINTER   = 12'h528;
   localparam logic [11:0] OUTBOUND_FREE_BOTTOM_INCREMENT = 12'h52C;
   localparam logic [11:0] OUTBOUND_FREE_TOP_POINTER      = 12'h530;
   localparam int          ADVANCE_BIT                    = 0;

   // ---------------------------------------------------------------
   // queue size codes and bus answers
   // ---------------------------------------------------------------
   localparam logic [2:0]  SIZE_1K    = 3'h1;
   localparam logic [2:0]  SIZE_4K    = 3'h2;
   localparam logic [2:0]  SIZE_16K   = 3'h3;
   localparam logic [2:0]  SIZE_64K   = 3'h4;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // bits of a pointer that an advance may change
   function automatic logic [17:0] size_mask(input logic [2:0] size);
      case (size)
         SIZE_4K:  size_mask = 18'h03FFC;
         SIZE_16K: size_mask = 18'h0FFFC;
         SIZE_64K: size_mask = 18'h3FFFC;
         default:  size_mask = 18'h00FFC;
      endcase
   endfunction : size_mask

endpackage : message_queue_pkg
